// ==== logic/ccl_map.vh ====
// Constants for the chain and test-port configuration loader
`ifndef CCL_MAP_VH
`define CCL_MAP_VH

// ==========================================================
// Test-port instruction codes (4-bit instruction register)
`define CCL_IR_W 4
`define CCL_IR_EXTEST 4'h0
`define CCL_IR_PROGRAM 4'h2
`define CCL_IR_SAMPLE 4'h5
`define CCL_IR_IDCODE 4'h6
`define CCL_IR_CONFIG_IO 4'hd
`define CCL_IR_RECONFIG_PULSE 4'he
`define CCL_IR_BYPASS 4'hf
`define CCL_IR_CAPTURE 4'h1

// ==========================================================
// Identification value (arbitrary, names no real part)
`define CCL_IDCODE_VAL 32'h0a5c3001

// ==========================================================
// Data register lengths
`define CCL_DR_LEN_BYPASS 6'd1
`define CCL_DR_LEN_SAMPLE 6'd4
`define CCL_DR_LEN_IDCODE 6'd32

// ==========================================================
// Stream format and byte FIFO size
`define CCL_FRAME_BYTES 16'h0040
`define CCL_RUN_ESCAPE 8'h00
`define CCL_SECURITY_KEY 8'h5a
`define CCL_FIFO_WIDTH 8
`define CCL_FIFO_DEPTH 32
`define CCL_FIFO_AW 5

// ==========================================================
// Timing counts
`define CCL_INIT_CLKS_JTAG 11'd1222
`define CCL_INIT_CLKS_SERIAL 11'd8
`define CCL_RESET_CYCLES 4'h8

`endif

// ==== logic/ccl_fifo.v ====
// Byte FIFO between the bit assembler and the decompressor
`timescale 1ns/1ns
`default_nettype none

module ccl_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk_sys,
   input wire rstn,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW:0] wr_ptr_reg;
   reg [AW:0] rd_ptr_reg;
   wire full;
   wire empty;

   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

   always @(posedge clk_sys) begin
      if (in_valid && !full) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk_sys) begin
      if (!rstn || flush) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ==== logic/ccl_config_ctrl.v ====
// Configuration-load control: serial chain loading and test-port loading
`timescale 1ns/1ns
`include "ccl_map.vh"
`default_nettype none

module ccl_config_ctrl (
   input wire clk_sys,
   input wire rstn,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo,
   output reg tdo_oe,
   input wire config_clock,
   input wire serial_config_data,
   input wire chain_enable_in_n,
   output reg chain_enable_out_n,
   input wire reconfig_request_n,
   input wire config_error_line_in,
   output reg config_error_line_out,
   output reg config_error_line_oe,
   input wire config_complete_in,
   output reg config_complete_out,
   output reg config_complete_oe,
   input wire stream_compressed,
   input wire security_enable,
   input wire global_clear_n,
   input wire global_output_enable,
   output reg user_clear_n,
   output reg user_output_enable
);

   // ==========================================================
   // Pin synchronisers
   localparam NP = 12;
   reg [NP-1:0] s1_reg;
   reg [NP-1:0] s2_reg;
   reg [NP-1:0] s3_reg;
   reg [NP-1:0] flt_reg;
   wire [NP-1:0] pins;
   assign pins = {config_complete_in, security_enable, stream_compressed, global_output_enable,
                  global_clear_n, config_error_line_in, reconfig_request_n, chain_enable_in_n,
                  serial_config_data, config_clock, tdi, tms};
   reg tck1_reg;
   reg tck2_reg;
   reg tck3_reg;
   reg tck_f_reg;
   reg tck_d_reg;
   reg config_clock_d_reg;

   // A level is taken only once the second and third stage agree
   always @(posedge clk_sys) begin
      if (!rstn) begin
         s1_reg <= {NP{1'b1}};
         s2_reg <= {NP{1'b1}};
         s3_reg <= {NP{1'b1}};
         flt_reg <= {NP{1'b1}};
         tck1_reg <= 1'b0;
         tck2_reg <= 1'b0;
         tck3_reg <= 1'b0;
         tck_f_reg <= 1'b0;
         tck_d_reg <= 1'b0;
         config_clock_d_reg <= 1'b1;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         flt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (flt_reg & (s2_reg ^ s3_reg));
         tck1_reg <= tck;
         tck2_reg <= tck1_reg;
         tck3_reg <= tck2_reg;
         if (tck2_reg == tck3_reg) begin
            tck_f_reg <= tck2_reg;
         end
         tck_d_reg <= tck_f_reg;
         config_clock_d_reg <= flt_reg[2];
      end
   end

   wire s_tms = flt_reg[0];
   wire s_tdi = flt_reg[1];
   wire s_config_clock = flt_reg[2];
   wire s_data = flt_reg[3];
   wire s_ce_n = flt_reg[4];
   wire s_reconf_n = flt_reg[5];
   wire s_err_line = flt_reg[6];
   wire s_gclr_n = flt_reg[7];
   wire s_goe = flt_reg[8];
   wire s_comp = flt_reg[9];
   wire s_sec = flt_reg[10];
   wire tck_rise = tck_f_reg && !tck_d_reg;
   wire tck_fall = !tck_f_reg && tck_d_reg;
   wire config_clock_rise = s_config_clock && !config_clock_d_reg;

   // ==========================================================
   // Test access port controller
   localparam T_TLR = 16'h0001, T_RTI = 16'h0002, T_SDR = 16'h0004, T_CDR = 16'h0008;
   localparam T_SHDR = 16'h0010, T_E1DR = 16'h0020, T_PDR = 16'h0040, T_E2DR = 16'h0080;
   localparam T_UDR = 16'h0100, T_SIR = 16'h0200, T_CIR = 16'h0400, T_SHIR = 16'h0800;
   localparam T_E1IR = 16'h1000, T_PIR = 16'h2000, T_E2IR = 16'h4000, T_UIR = 16'h8000;
   reg [15:0] tap_reg;
   reg [15:0] tap_next;

   always @* begin
      case (tap_reg)
         T_TLR: tap_next = s_tms ? T_TLR : T_RTI;
         T_RTI: tap_next = s_tms ? T_SDR : T_RTI;
         T_SDR: tap_next = s_tms ? T_SIR : T_CDR;
         T_CDR: tap_next = s_tms ? T_E1DR : T_SHDR;
         T_SHDR: tap_next = s_tms ? T_E1DR : T_SHDR;
         T_E1DR: tap_next = s_tms ? T_UDR : T_PDR;
         T_PDR: tap_next = s_tms ? T_E2DR : T_PDR;
         T_E2DR: tap_next = s_tms ? T_UDR : T_SHDR;
         T_UDR: tap_next = s_tms ? T_SDR : T_RTI;
         T_SIR: tap_next = s_tms ? T_TLR : T_CIR;
         T_CIR: tap_next = s_tms ? T_E1IR : T_SHIR;
         T_SHIR: tap_next = s_tms ? T_E1IR : T_SHIR;
         T_E1IR: tap_next = s_tms ? T_UIR : T_PIR;
         T_PIR: tap_next = s_tms ? T_E2IR : T_PIR;
         T_E2IR: tap_next = s_tms ? T_UIR : T_SHIR;
         T_UIR: tap_next = s_tms ? T_SDR : T_RTI;
         default: tap_next = T_TLR;
      endcase
   end

   // ==========================================================
   // Configuration states
   localparam C_RESET = 7'h01, C_WAIT = 7'h02, C_LOAD = 7'h04, C_INIT = 7'h08;
   localparam C_USER = 7'h10, C_ERROR = 7'h20, C_HALT = 7'h40;
   reg [6:0] cfg_reg;
   reg jtag_mode_reg;
   reg io_unlock_reg;
   reg [3:0] ir_reg;
   reg [3:0] ir_sh_reg;
   reg [31:0] dr_reg;
   reg [3:0] rst_cnt_reg;

   wire upd_ir = tck_fall && (tap_reg == T_UIR);
   wire ir_test_ok = (ir_sh_reg == `CCL_IR_BYPASS) || (ir_sh_reg == `CCL_IR_IDCODE) ||
                     (ir_sh_reg == `CCL_IR_SAMPLE);
   wire ir_cfg_op = (ir_sh_reg == `CCL_IR_CONFIG_IO) || (ir_sh_reg == `CCL_IR_PROGRAM) ||
                    (ir_sh_reg == `CCL_IR_RECONFIG_PULSE);
   wire unlocked = io_unlock_reg || (cfg_reg == C_USER);
   wire [3:0] ir_take = (ir_test_ok || ir_cfg_op || unlocked) ? ir_sh_reg : `CCL_IR_BYPASS;
   wire go_prog = upd_ir && (ir_take == `CCL_IR_PROGRAM);
   wire go_io = upd_ir && (ir_take == `CCL_IR_CONFIG_IO);
   wire go_pulse = upd_ir && (ir_take == `CCL_IR_RECONFIG_PULSE);
   wire restart = !s_reconf_n || go_pulse;
   wire [5:0] dr_len = (ir_reg == `CCL_IR_IDCODE) ? `CCL_DR_LEN_IDCODE :
                       (ir_reg == `CCL_IR_SAMPLE) ? `CCL_DR_LEN_SAMPLE : `CCL_DR_LEN_BYPASS;

   always @(posedge clk_sys) begin
      if (!rstn) begin
         tap_reg <= T_TLR;
         ir_reg <= `CCL_IR_IDCODE;
         ir_sh_reg <= 4'h0;
         dr_reg <= 32'h0;
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         if (tck_rise) begin
            tap_reg <= tap_next;
            if (tap_reg == T_CIR) begin
               ir_sh_reg <= `CCL_IR_CAPTURE;
            end else if (tap_reg == T_SHIR) begin
               ir_sh_reg <= {s_tdi, ir_sh_reg[3:1]};
            end
            if (tap_reg == T_CDR) begin
               if (ir_reg == `CCL_IR_IDCODE) begin
                  dr_reg <= `CCL_IDCODE_VAL;
               end else if (ir_reg == `CCL_IR_SAMPLE) begin
                  dr_reg <= {28'h0, s_err_line, s_reconf_n, s_ce_n, s_data};
               end else begin
                  dr_reg <= 32'h0;
               end
            end else if (tap_reg == T_SHDR) begin
               if (dr_len == `CCL_DR_LEN_IDCODE) begin
                  dr_reg <= {s_tdi, dr_reg[31:1]};
               end else if (dr_len == `CCL_DR_LEN_SAMPLE) begin
                  dr_reg <= {28'h0, s_tdi, dr_reg[3:1]};
               end else begin
                  dr_reg <= {31'h0, s_tdi};
               end
            end
         end
         if (tck_fall) begin
            tdo_oe <= (tap_reg == T_SHIR) || (tap_reg == T_SHDR);
            if (tap_reg == T_SHIR) begin
               tdo <= ir_sh_reg[0];
            end else if (tap_reg == T_SHDR) begin
               tdo <= dr_reg[0];
            end
            if (tap_reg == T_TLR) begin
               ir_reg <= `CCL_IR_IDCODE;
            end else if (tap_reg == T_UIR) begin
               ir_reg <= ir_take;
            end
         end
      end
   end

   // ==========================================================
   // Bit collection and byte assembly
   reg [7:0] byte_sr_reg;
   reg [2:0] bit_cnt_reg;
   reg [7:0] pend_reg;
   reg pend_vld_reg;
   reg overrun_reg;
   wire fifo_in_ready;
   wire jtag_bit = tck_rise && (tap_reg == T_SHDR) && (ir_reg == `CCL_IR_PROGRAM) && jtag_mode_reg;
   // Serial bits are ignored once the test port owns the load
   wire ser_bit = config_clock_rise && !s_ce_n && !jtag_mode_reg;
   wire bit_vld = (cfg_reg == C_LOAD) && (jtag_bit || ser_bit);
   wire bit_val = jtag_mode_reg ? s_tdi : s_data;
   wire start = go_prog || ((cfg_reg == C_WAIT) && !s_ce_n);
   wire flush = (cfg_reg != C_LOAD) || start;
   wire [7:0] full_byte = {bit_val, byte_sr_reg[7:1]};
   // Decryption is only offered to the serial schemes
   wire [7:0] clear_byte = (s_sec && !jtag_mode_reg) ? (full_byte ^ `CCL_SECURITY_KEY) : full_byte;

   always @(posedge clk_sys) begin
      if (!rstn || flush) begin
         byte_sr_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         pend_reg <= 8'h00;
         pend_vld_reg <= 1'b0;
         overrun_reg <= 1'b0;
      end else begin
         if (pend_vld_reg && fifo_in_ready) begin
            pend_vld_reg <= 1'b0;
         end
         if (bit_vld) begin
            byte_sr_reg <= full_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
               pend_reg <= clear_byte;
               pend_vld_reg <= 1'b1;
               // A held byte not yet taken would be lost; the pin clock cannot be stalled
               if (pend_vld_reg && !fifo_in_ready) begin
                  overrun_reg <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Buffer and on-the-fly run-length expansion
   wire fifo_vld;
   wire [7:0] fifo_data;
   reg [7:0] run_cnt_reg;
   reg esc_reg;
   wire fifo_rdy = (run_cnt_reg == 8'h00);
   wire comp_on = s_comp && !jtag_mode_reg;

   ccl_fifo #(
      .WIDTH(`CCL_FIFO_WIDTH),
      .DEPTH(`CCL_FIFO_DEPTH),
      .AW(`CCL_FIFO_AW)
   ) i_ccl_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .flush(flush),
      .in_valid(pend_vld_reg),
      .in_ready(fifo_in_ready),
      .in_data(pend_reg),
      .out_valid(fifo_vld),
      .out_ready(fifo_rdy),
      .out_data(fifo_data)
   );

   wire take = fifo_vld && fifo_rdy;
   wire is_esc = comp_on && !esc_reg && (fifo_data == `CCL_RUN_ESCAPE);
   wire out_vld = (run_cnt_reg != 8'h00) || (take && !is_esc);
   wire [7:0] out_byte = ((run_cnt_reg != 8'h00) || esc_reg) ? 8'h00 : fifo_data;

   always @(posedge clk_sys) begin
      if (!rstn || flush) begin
         run_cnt_reg <= 8'h00;
         esc_reg <= 1'b0;
      end else if (run_cnt_reg != 8'h00) begin
         run_cnt_reg <= run_cnt_reg - 8'h01;
      end else if (take) begin
         // Escape then count n gives n+1 zero bytes
         esc_reg <= is_esc;
         if (esc_reg) begin
            run_cnt_reg <= fifo_data;
         end
      end
   end

   // ==========================================================
   // Frame check, initialisation and completion
   reg [15:0] byte_cnt_reg;
   reg [7:0] sum_reg;
   reg [10:0] init_cnt_reg;
   wire init_clk = jtag_mode_reg ? tck_rise : config_clock_rise;
   wire [10:0] init_need = jtag_mode_reg ? `CCL_INIT_CLKS_JTAG : `CCL_INIT_CLKS_SERIAL;
   reg [4:0] oe_hist_reg;
   // Ignore lows still in flight from our own release
   wire ext_err = !s_err_line && !config_error_line_oe && (oe_hist_reg == 5'h00);
   wire busy = (cfg_reg == C_LOAD) || (cfg_reg == C_INIT);

   always @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_reg <= C_RESET;
         rst_cnt_reg <= 4'h0;
         jtag_mode_reg <= 1'b0;
         io_unlock_reg <= 1'b0;
         byte_cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
         init_cnt_reg <= 11'h000;
      end else if (restart) begin
         cfg_reg <= C_RESET;
         rst_cnt_reg <= 4'h0;
         jtag_mode_reg <= 1'b0;
         io_unlock_reg <= 1'b0;
      end else if (go_io) begin
         io_unlock_reg <= 1'b1;
         if (cfg_reg != C_USER) begin
            cfg_reg <= C_HALT;
         end
      end else if (start) begin
         cfg_reg <= C_LOAD;
         jtag_mode_reg <= go_prog || jtag_mode_reg;
         byte_cnt_reg <= 16'h0000;
         sum_reg <= 8'h00;
         init_cnt_reg <= 11'h000;
      end else begin
         case (cfg_reg)
            C_RESET: begin
               rst_cnt_reg <= rst_cnt_reg + 4'h1;
               if (rst_cnt_reg == `CCL_RESET_CYCLES) begin
                  cfg_reg <= C_WAIT;
               end
            end
            C_WAIT: cfg_reg <= C_WAIT;
            C_LOAD: begin
               if (overrun_reg || ext_err) begin
                  cfg_reg <= C_ERROR;
               end else if (out_vld) begin
                  byte_cnt_reg <= byte_cnt_reg + 16'h0001;
                  sum_reg <= sum_reg + out_byte;
                  if (byte_cnt_reg == `CCL_FRAME_BYTES - 16'h0001) begin
                     cfg_reg <= (out_byte == sum_reg) ? C_INIT : C_ERROR;
                  end
               end
            end
            C_INIT: begin
               if (ext_err) begin
                  cfg_reg <= C_ERROR;
               end else if (init_cnt_reg == init_need) begin
                  cfg_reg <= C_USER;
               end else if (init_clk) begin
                  init_cnt_reg <= init_cnt_reg + 11'h001;
               end
            end
            C_USER: cfg_reg <= C_USER;
            C_ERROR: cfg_reg <= C_ERROR;
            C_HALT: cfg_reg <= C_HALT;
            default: cfg_reg <= C_RESET;
         endcase
      end
   end

   // ==========================================================
   // Pin drivers
   always @(posedge clk_sys) begin
      if (!rstn) begin
         chain_enable_out_n <= 1'b1;
         config_error_line_out <= 1'b0;
         config_error_line_oe <= 1'b1;
         oe_hist_reg <= 5'h1f;
         config_complete_out <= 1'b0;
         config_complete_oe <= 1'b1;
         user_clear_n <= 1'b0;
         user_output_enable <= 1'b0;
      end else begin
         chain_enable_out_n <= (cfg_reg != C_USER);
         config_error_line_out <= 1'b0;
         // Held low during reset and after a detected fault, so the whole chain stops
         config_error_line_oe <= (cfg_reg == C_RESET) || (cfg_reg == C_ERROR);
         oe_hist_reg <= {oe_hist_reg[3:0], config_error_line_oe};
         config_complete_out <= 1'b0;
         // Released to the pull-up on success, driven low otherwise
         config_complete_oe <= (cfg_reg != C_USER) && !busy || (cfg_reg == C_LOAD) || (cfg_reg == C_INIT);
         // Global pins steer only user logic; the test port path never reads them
         user_clear_n <= s_gclr_n;
         user_output_enable <= s_goe && (cfg_reg == C_USER);
      end
   end

endmodule

`default_nettype wire

// ==== verification/ccl_chk.sv ====
// Port-level checks for the configuration loader
`timescale 1ns/1ns
`default_nettype none
module ccl_chk (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic chain_enable_out_n,
   input wire logic reconfig_request_n,
   input wire logic config_error_line_out,
   input wire logic config_error_line_oe,
   input wire logic config_complete_out,
   input wire logic config_complete_oe,
   input wire logic global_clear_n,
   input wire logic user_clear_n,
   input wire logic user_output_enable
);
   // =====
   // Cycles since tck fell; saturates when idle
   logic tck_reg;
   logic [3:0] age_reg;
   always @(posedge clk_sys) begin
      tck_reg <= tck;
      if (!rstn)
         age_reg <= 4'hf;
      else if (tck_reg && !tck)
         age_reg <= 4'h0;
      else if (age_reg != 4'hf)
         age_reg <= age_reg + 4'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // =====
   // Assertions
   tdo_edge_a: assert property ($changed(tdo) |-> age_reg < 4'ha)
      else $error("tdo off tck fall");
   tdo_oe_edge_a: assert property ($changed(tdo_oe) |-> age_reg < 4'ha)
      else $error("tdo_oe off tck fall");
   chain_after_done_a: assert property ($fell(chain_enable_out_n) |-> !config_complete_oe)
      else $error("chain before done");
   done_then_chain_a: assert property ($fell(config_complete_oe) |-> ##[0:3] !chain_enable_out_n)
      else $error("chain late");
   err_drive_a: assert property (config_error_line_oe |-> !config_error_line_out)
      else $error("error line high");
   err_hold_a: assert property ($rose(config_error_line_oe) |=> config_error_line_oe [*8])
      else $error("error line short");
   done_drive_a: assert property (config_complete_oe |-> !config_complete_out)
      else $error("complete high");
   err_not_done_a: assert property (config_error_line_oe |-> config_complete_oe)
      else $error("complete in error");
   restart_hold_a: assert property (!reconfig_request_n [*8] |-> config_error_line_oe && config_complete_oe)
      else $error("restart ignored");
   clear_mirror_a: assert property ($changed(global_clear_n) |-> ##[1:8] user_clear_n == global_clear_n)
      else $error("clear not mirrored");
   uoe_user_a: assert property ($rose(user_output_enable) |-> !chain_enable_out_n)
      else $error("oe outside user");
endmodule
bind ccl_config_ctrl ccl_chk i_ccl_chk (
   .clk_sys(clk_sys),
   .rstn(rstn),
   .tck(tck),
   .tdo(tdo),
   .tdo_oe(tdo_oe),
   .chain_enable_out_n(chain_enable_out_n),
   .reconfig_request_n(reconfig_request_n),
   .config_error_line_out(config_error_line_out),
   .config_error_line_oe(config_error_line_oe),
   .config_complete_out(config_complete_out),
   .config_complete_oe(config_complete_oe),
   .global_clear_n(global_clear_n),
   .user_clear_n(user_clear_n),
   .user_output_enable(user_output_enable)
);
`default_nettype wire

// ==== verification/ccl_host.sv ====
// Host model: serial configuration source and test-port driver
`timescale 1ns/1ns
`include "ccl_map.vh"
`default_nettype none
module ccl_host (
   input wire logic clk_sys,
   input wire logic tdo,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic config_clock,
   output logic serial_config_data
);
   logic [7:0] bytes_q[$];
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      config_clock = 1'b0;
      serial_config_data = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // =====
   // Serial source; one stream kind per frame, never mixed
   task automatic ser_send(input int extra);
      int i;
      int nb;
      nb = bytes_q.size() * 8;
      for (i = 0; i < nb + extra; i++) begin
         config_clock <= 1'b0;
         if (i < nb)
            serial_config_data <= bytes_q[i / 8][i % 8];
         else
            serial_config_data <= ~serial_config_data;
         cyc(8);
         config_clock <= 1'b1;
         cyc(8);
      end
      config_clock <= 1'b0;
      serial_config_data <= ~serial_config_data;
      bytes_q.delete();
   endtask
   // =====
   // Test port; tdo is read late in the low half
   task automatic jbit(input logic m, input logic d, output logic o);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      cyc(7);
      o = tdo;
      cyc(1);
      tck <= 1'b1;
      cyc(8);
   endtask
   task automatic tap_reset();
      logic o;
      repeat (5) jbit(1'b1, ~tdi, o);
      jbit(1'b0, ~tdi, o);
   endtask
   task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic o;
      int i;
      dout = 32'h0;
      jbit(1'b1, ~tdi, o);
      if (ir)
         jbit(1'b1, ~tdi, o);
      jbit(1'b0, ~tdi, o);
      jbit(1'b0, ~tdi, o);
      for (i = 0; i < n; i++) begin
         jbit(i == n - 1, (n > 32) ? bytes_q[i / 8][i % 8] : din[i], o);
         if (i < 32)
            dout[i] = o;
      end
      jbit(1'b1, ~tdi, o);
      jbit(1'b0, ~tdi, o);
      bytes_q.delete();
   endtask
   task automatic jtag_load();
      logic [31:0] d;
      logic o;
      shift(1'b0, bytes_q.size() * 8, 32'h0, d);
      repeat (`CCL_INIT_CLKS_JTAG) jbit(1'b0, ~tdi, o);
   endtask
endmodule
`default_nettype wire

// ==== verification/ccl_config_ctrl_tb.sv ====
// Self-checking bench for the configuration loader
`timescale 1ns/1ns
`include "ccl_map.vh"
`default_nettype none
module ccl_config_ctrl_tb;
   logic clk_sys, rstn, tck, tms, tdi, tdo, tdo_oe, config_clock, serial_config_data;
   logic chain_enable_in_n, chain_enable_out_n, reconfig_request_n;
   logic config_error_line_in, config_error_line_out, config_error_line_oe;
   logic config_complete_in, config_complete_out, config_complete_oe;
   logic stream_compressed, security_enable, global_clear_n, global_output_enable;
   logic user_clear_n, user_output_enable;
   logic [7:0] s;
   logic [31:0] d;
   localparam logic [31:0] PAT = 32'hc3a50f96;
   int error_cnt = 0;
   int tests_run = 0;
   // Both shared lines have pull-ups on the board
   assign config_error_line_in = config_error_line_oe ? config_error_line_out : 1'b1;
   assign config_complete_in = config_complete_oe ? config_complete_out : 1'b1;
   ccl_config_ctrl i_ccl_config_ctrl (.*);
   ccl_host i_ccl_host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // =====
   // Common tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk_bit(input logic g, input logic e, input string m);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t %s got %h", $time, m, g);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Byte 0 is an escape code on purpose
   task automatic mk_frame(input logic [7:0] bad, input logic [7:0] k = 8'h00);
      int i;
      s = 8'h00;
      for (i = 0; i < 63; i++) begin
         i_ccl_host.bytes_q.push_back(8'(i * 5) ^ k);
         s = s + 8'(i * 5);
      end
      i_ccl_host.bytes_q.push_back((s + bad) ^ k);
   endtask
   task automatic chk_done();
      int i;
      for (i = 0; i < 400 && chain_enable_out_n !== 1'b0; i++)
         cyc(1);
      if (chain_enable_out_n !== 1'b0) begin
         error_cnt++;
         $display("BAD %0t no done", $time);
         conclude();
      end
      chk_bit(config_complete_oe, 1'b0, "complete low");
      chk_bit(config_error_line_oe, 1'b0, "err pulled");
   endtask
   task automatic restart();
      reconfig_request_n <= 1'b0;
      cyc(12);
      reconfig_request_n <= 1'b1;
      cyc(40);
      chk_bit(config_complete_oe, 1'b1, "done after restart");
      chk_bit(chain_enable_out_n, 1'b1, "chain after restart");
      chk_bit(config_error_line_oe, 1'b0, "err after restart");
   endtask
   task automatic chk_bypass(input logic [31:0] g);
      chk_word(g, {PAT[30:0], 1'b0}, "bypass delay");
   endtask
   // =====
   // Scenarios
   task automatic t_serial();
      mk_frame(8'h00);
      i_ccl_host.ser_send(`CCL_INIT_CLKS_SERIAL);
      chk_done();
      restart();
      stream_compressed <= 1'b1;
      i_ccl_host.bytes_q = '{8'h00, 8'h3e, 8'h00, 8'h00};
      i_ccl_host.ser_send(`CCL_INIT_CLKS_SERIAL);
      chk_done();
      stream_compressed <= 1'b0;
      restart();
      $display("serial loads done");
   endtask
   task automatic t_refused();
      mk_frame(8'h01);
      i_ccl_host.ser_send(`CCL_INIT_CLKS_SERIAL);
      cyc(40);
      chk_bit(config_error_line_oe, 1'b1, "bad sum not flagged");
      chk_bit(config_complete_oe, 1'b1, "bad sum done");
      restart();
      chain_enable_in_n <= 1'b1;
      mk_frame(8'h00);
      i_ccl_host.ser_send(`CCL_INIT_CLKS_SERIAL);
      cyc(40);
      chk_bit(config_complete_oe, 1'b1, "loaded while chain disabled");
      chain_enable_in_n <= 1'b0;
      restart();
      $display("refused loads done");
   endtask
   task automatic t_testport();
      i_ccl_host.tap_reset();
      i_ccl_host.shift(1'b0, 32, PAT, d);
      chk_word(d, `CCL_IDCODE_VAL, "idcode");
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_BYPASS}, d);
      global_clear_n <= 1'b0;
      i_ccl_host.shift(1'b0, 32, PAT, d);
      global_clear_n <= 1'b1;
      chk_bypass(d);
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_SAMPLE}, d);
      i_ccl_host.shift(1'b0, 4, PAT, d);
      chk_word({28'h0, d[3:1], 1'b0}, 32'hc, "sample capture");
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_EXTEST}, d);
      i_ccl_host.shift(1'b0, 32, PAT, d);
      chk_bypass(d);
      $display("test port locked done");
   endtask
   task automatic t_config_io();
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_CONFIG_IO}, d);
      mk_frame(8'h00);
      i_ccl_host.ser_send(`CCL_INIT_CLKS_SERIAL);
      cyc(40);
      chk_bit(config_complete_oe, 1'b1, "load not halted");
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_RECONFIG_PULSE}, d);
      cyc(40);
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_EXTEST}, d);
      i_ccl_host.shift(1'b0, 32, PAT, d);
      chk_bypass(d);
      $display("io setup done");
   endtask
   task automatic t_jtag_load();
      chain_enable_in_n <= 1'b1;
      stream_compressed <= 1'b1;
      security_enable <= 1'b1;
      i_ccl_host.shift(1'b1, 4, {28'h0, `CCL_IR_PROGRAM}, d);
      mk_frame(8'h00);
      i_ccl_host.jtag_load();
      chk_done();
      chain_enable_in_n <= 1'b0;
      stream_compressed <= 1'b0;
      security_enable <= 1'b0;
      restart();
      $display("test port load done");
   endtask
   task automatic t_secure();
      security_enable <= 1'b1;
      mk_frame(8'h00, `CCL_SECURITY_KEY);
      i_ccl_host.ser_send(`CCL_INIT_CLKS_SERIAL);
      chk_done();
      chk_bit(user_output_enable, 1'b1, "no output enable");
      chk_bit(user_clear_n, 1'b1, "clear held");
      security_enable <= 1'b0;
      $display("secure load done");
   endtask
   initial begin
      rstn = 1'b0;
      chain_enable_in_n = 1'b0;
      reconfig_request_n = 1'b1;
      stream_compressed = 1'b0;
      security_enable = 1'b0;
      global_clear_n = 1'b1;
      global_output_enable = 1'b1;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      cyc(40);
      chk_bit(config_complete_oe, 1'b1, "done at start");
      chk_bit(config_error_line_oe, 1'b0, "err at start");
      t_serial();
      t_refused();
      t_testport();
      t_config_io();
      t_jtag_load();
      t_secure();
      conclude();
   end
endmodule
`default_nettype wire
